// ===== fbo_pkg.sv
package fbo_pkg;
  localparam int CLK_HZ = 25000000;
  // access time allowed for a read, ns, as set for the slowest grade
  localparam int READ_ACCESS_NS = 150;
  localparam int READ_ACCESS_CYC =
    ((READ_ACCESS_NS * (CLK_HZ / 1000000)) + 999) / 1000;
  // write strobe low time, ns
  localparam int WRITE_PULSE_NS = 80;
  localparam int WRITE_PULSE_CYC =
    ((WRITE_PULSE_NS * (CLK_HZ / 1000000)) + 999) / 1000;
  // hardware reset pulse, ns
  localparam int RESET_PULSE_NS = 500;
  localparam int RESET_PULSE_CYC =
    ((RESET_PULSE_NS * (CLK_HZ / 1000000)) + 999) / 1000;
  // recovery after reset release before first access, ns
  localparam int RESET_RECOVER_NS = 50;
  localparam int RESET_RECOVER_CYC =
    ((RESET_RECOVER_NS * (CLK_HZ / 1000000)) + 999) / 1000;
  // gap between strobes, ns
  localparam int GAP_NS = 40;
  localparam int GAP_CYC = ((GAP_NS * (CLK_HZ / 1000000)) + 999) / 1000;
  localparam int CNT_W = 8;
  localparam int ADDR_W = 18;
  localparam int DATA_W = 16;
  localparam int LOW_W = 8;
  localparam int TOP_BIT = 15;
  localparam logic [1:0] OP_READ = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_RESET = 2'h2;
endpackage

// ===== fbo_timer.sv
`timescale 1ns/10ps
module fbo_timer
  import fbo_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // control
  input wire logic load,
  input wire logic [CNT_W-1:0] count,
  output logic expired
);
  logic [CNT_W-1:0] remain;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      remain <= 8'h00;
    end else if (load) begin
      remain <= count;
    end else if (remain != 8'h00) begin
      remain <= remain - 8'h01;
    end
  end

  // plain count state; the host feeds expired back into load, so no path from load here
  assign expired = (remain == 8'h00);
endmodule

// ===== fbo_host.sv
`timescale 1ns/10ps
// How it works
// - in byte mode the top lane carries the low byte address bit.
// - read drives chip select and output enable low, write strobe high.
// - write drives write strobe and chip select low, output enable high.
// - identification reads use the ordinary read cycle.
module fbo_host
  import fbo_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // request side
  input wire logic req_valid,
  input wire logic [1:0] req_op,
  input wire logic req_word_mode,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic req_byte_lsb,
  input wire logic [DATA_W-1:0] req_wdata,
  output logic req_ready,
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_rdata,
  // flash pins
  output logic chip_sel_n,
  output logic out_en_n,
  output logic write_n,
  output logic reset_n,
  output logic width_sel,
  output logic [ADDR_W-1:0] word_address_bus,
  input wire logic [DATA_W-1:0] data_in,
  output logic [DATA_W-1:0] data_out,
  output logic [DATA_W-1:0] data_oe_n,
  input wire logic operation_done_n,
  output logic busy
);
  typedef enum logic [2:0] {
    FBO_IDLE = 3'b000,
    FBO_READ = 3'b001,
    FBO_WRITE = 3'b010,
    FBO_RESET = 3'b011,
    FBO_RECOVER = 3'b100,
    FBO_GAP = 3'b101
  } fbo_state_type;

  fbo_state_type state;
  logic tmr_load;
  logic [CNT_W-1:0] tmr_count;
  logic tmr_expired;
  logic word_mode;

  // lane enable pattern (active low) for a write in the given width
  function automatic logic [DATA_W-1:0] lane_oe_n(input logic wmode);
    lane_oe_n = wmode ? 16'h0000 : 16'h7F00;
  endfunction

  fbo_timer u_timer (
    .core_clk(core_clk),
    .rst(rst),
    .load(tmr_load),
    .count(tmr_count),
    .expired(tmr_expired)
  );

  always_comb begin
    tmr_load = 1'b0;
    tmr_count = 8'h00;
    case (state)
      FBO_IDLE: begin
        if (req_valid) begin
          tmr_load = 1'b1;
          case (req_op)
            OP_READ: tmr_count = CNT_W'(READ_ACCESS_CYC);
            OP_WRITE: tmr_count = CNT_W'(WRITE_PULSE_CYC);
            OP_RESET: tmr_count = CNT_W'(RESET_PULSE_CYC);
            default: tmr_count = 8'h00;
          endcase
        end
      end
      FBO_READ, FBO_WRITE: begin
        if (tmr_expired) begin
          tmr_load = 1'b1;
          tmr_count = CNT_W'(GAP_CYC);
        end
      end
      FBO_RESET: begin
        if (tmr_expired) begin
          tmr_load = 1'b1;
          tmr_count = CNT_W'(RESET_RECOVER_CYC);
        end
      end
      default: begin
        tmr_load = 1'b0;
      end
    endcase
  end

  // sequencer
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= FBO_IDLE;
    end else begin
      case (state)
        FBO_IDLE: begin
          if (req_valid) begin
            case (req_op)
              OP_READ: state <= FBO_READ;
              OP_WRITE: state <= FBO_WRITE;
              OP_RESET: state <= FBO_RESET;
              default: state <= FBO_IDLE;
            endcase
          end
        end
        FBO_READ, FBO_WRITE: begin
          if (tmr_expired) begin
            state <= FBO_GAP;
          end
        end
        FBO_RESET: begin
          if (tmr_expired) begin
            state <= FBO_RECOVER;
          end
        end
        FBO_RECOVER, FBO_GAP: begin
          if (tmr_expired) begin
            state <= FBO_IDLE;
          end
        end
        default: begin
          state <= FBO_IDLE;
        end
      endcase
    end
  end

  // strobes
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      chip_sel_n <= 1'b1;
      out_en_n <= 1'b1;
      write_n <= 1'b1;
      reset_n <= 1'b1;
    end else begin
      chip_sel_n <= 1'b1;
      out_en_n <= 1'b1;
      write_n <= 1'b1;
      reset_n <= 1'b1;
      if (state == FBO_IDLE && req_valid && req_op == OP_READ) begin
        chip_sel_n <= 1'b0;
        out_en_n <= 1'b0;
      end else if (state == FBO_READ && !tmr_expired) begin
        chip_sel_n <= 1'b0;
        out_en_n <= 1'b0;
      end else if (state == FBO_IDLE && req_valid && req_op == OP_WRITE) begin
        chip_sel_n <= 1'b0;
        write_n <= 1'b0;
      end else if (state == FBO_WRITE && !tmr_expired) begin
        chip_sel_n <= 1'b0;
        write_n <= 1'b0;
      end else if (state == FBO_IDLE && req_valid && req_op == OP_RESET) begin
        reset_n <= 1'b0;
      end else if (state == FBO_RESET && !tmr_expired) begin
        reset_n <= 1'b0;
      end
    end
  end

  // address, width and data lanes, captured at request take
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      word_mode <= 1'b1;
      width_sel <= 1'b1;
      word_address_bus <= 18'h00000;
      data_out <= 16'h0000;
      data_oe_n <= 16'hFFFF;
    end else if (state == FBO_IDLE && req_valid) begin
      word_mode <= req_word_mode;
      width_sel <= req_word_mode;
      word_address_bus <= req_addr;
      data_out <= req_wdata;
      if (!req_word_mode) begin
        data_out[TOP_BIT] <= req_byte_lsb;
      end
      if (req_op == OP_WRITE) begin
        data_oe_n <= lane_oe_n(req_word_mode);
      end else if (req_op == OP_READ && !req_word_mode) begin
        data_oe_n <= 16'h7FFF;
      end else begin
        data_oe_n <= 16'hFFFF;
      end
    end else if (state == FBO_GAP || state == FBO_RECOVER) begin
      data_oe_n <= 16'hFFFF;
    end
  end

  // response and handshake
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= 16'h0000;
      req_ready <= 1'b0;
      busy <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      req_ready <= (state == FBO_IDLE) && !req_valid;
      busy <= !operation_done_n;
      if (state == FBO_READ && tmr_expired && !out_en_n) begin
        rsp_valid <= 1'b1;
        rsp_rdata <= word_mode ? data_in : {8'h00, data_in[LOW_W-1:0]};
      end
    end
  end
endmodule

// ===== fbo_host_checker.sv
`timescale 1ns/10ps
module fbo_chk(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // watched ports
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic chip_sel_n,
  input wire logic out_en_n,
  input wire logic write_n,
  input wire logic reset_n,
  input wire logic width_sel,
  input wire logic [15:0] data_oe_n
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_no_oe_we: assert property (!(!out_en_n && !write_n)) else $error("oe and we low");
  a_read_pins: assert property ($fell(out_en_n) |-> !chip_sel_n && write_n) else $error("rd");
  a_write_pins: assert property ($fell(write_n) |-> !chip_sel_n && out_en_n) else $error("wr");
  a_read_len: assert property ($fell(out_en_n) |-> !out_en_n [*5] ##1 (out_en_n && rsp_valid))
    else $error("read length");
  a_write_len: assert property ($fell(write_n) |-> !write_n [*3] ##1 write_n) else $error("wlen");
  a_byte_mid: assert property (!width_sel |-> data_oe_n[14:8] == 7'h7F) else $error("mid");
  a_read_float: assert property (!out_en_n && width_sel |-> &data_oe_n) else $error("flt");
  a_idle_high: assert property (req_ready |-> chip_sel_n && reset_n) else $error("idle");
  a_reset_len: assert property ($fell(reset_n) |-> ##13 !reset_n ##1 reset_n)
    else $error("reset pulse");
  cover property ($rose(rsp_valid));
  cover property ($fell(write_n));
  cover property ($fell(reset_n));
endmodule
bind fbo_host fbo_chk fbo_chk_inst (
  .core_clk(core_clk),
  .rst(rst),
  .req_ready(req_ready),
  .rsp_valid(rsp_valid),
  .chip_sel_n(chip_sel_n),
  .out_en_n(out_en_n),
  .write_n(write_n),
  .reset_n(reset_n),
  .width_sel(width_sel),
  .data_oe_n(data_oe_n)
);

// ===== fbo_flash_model.sv
`timescale 1ns/10ps
module fbo_flash_model(
  // pins
  input wire logic core_clk,
  input wire logic chip_sel_n,
  input wire logic out_en_n,
  input wire logic write_n,
  input wire logic reset_n,
  input wire logic width_sel,
  input wire logic [17:0] word_address_bus,
  input wire logic [15:0] data_out,
  input wire logic [15:0] data_oe_n,
  output logic [15:0] data_in,
  output logic operation_done_n
);
  logic [1:0] mode = 2'h0;
  logic [3:0] cnt = 4'h0;
  logic wprev = 1'b1;
  logic [15:0] word, q, last = 16'h0000;
  wire on = !chip_sel_n && !out_en_n && write_n && reset_n;
  wire [15:0] den = on ? (width_sel ? 16'hFFFF : 16'h00FF) : 16'h0000;
  always_comb begin
    word = mode == 2'h0 ? word_address_bus[15:0] ^ 16'hA5C3 : mode == 2'h1 ? 16'h005A : 16'h004C;
    q = width_sel ? word : {8'h00, data_out[15] ? word[15:8] : word[7:0]};
  end
  // released lanes toggle so no stale value reads back
  assign data_in = (~data_oe_n & data_out) | (data_oe_n & den & q) | (data_oe_n & ~den & ~last);
  assign operation_done_n = mode != 2'h2;
  always_ff @(posedge core_clk) begin
    wprev <= write_n;
    last <= data_in;
    if (!reset_n) begin
      mode <= 2'h0;
      cnt <= 4'h0;
    end else if (!write_n && wprev && !chip_sel_n && out_en_n) begin
      mode <= data_out[7:0] == 8'h90 ? 2'h1 : data_out[7:0] == 8'hF0 ? 2'h0 : 2'h2;
      cnt <= 4'hF;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
      if (cnt == 4'h1 && mode == 2'h2)
        mode <= 2'h0;
    end
  end
endmodule

// ===== tb_fbo_host.sv
`timescale 1ns/10ps
module tb_fbo_host;
  import fbo_pkg::*;
  logic core_clk = 0, rst = 1, req_valid = 0, req_word_mode = 1, req_byte_lsb = 0;
  logic [1:0] req_op = 0;
  logic [17:0] req_addr = 0, word_address_bus;
  logic [15:0] req_wdata = 0, rsp_rdata, data_in, data_out, data_oe_n;
  logic req_ready, rsp_valid, chip_sel_n, out_en_n, write_n, reset_n, width_sel, busy;
  logic operation_done_n;
  int errors = 0, checks_done = 0;
  fbo_host fbo_host_inst (
    .core_clk(core_clk),
    .rst(rst),
    .req_valid(req_valid),
    .req_op(req_op),
    .req_word_mode(req_word_mode),
    .req_addr(req_addr),
    .req_byte_lsb(req_byte_lsb),
    .req_wdata(req_wdata),
    .req_ready(req_ready),
    .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata),
    .chip_sel_n(chip_sel_n),
    .out_en_n(out_en_n),
    .write_n(write_n),
    .reset_n(reset_n),
    .width_sel(width_sel),
    .word_address_bus(word_address_bus),
    .data_in(data_in),
    .data_out(data_out),
    .data_oe_n(data_oe_n),
    .operation_done_n(operation_done_n),
    .busy(busy)
  );
  fbo_flash_model fbo_flash_model_inst (
    .core_clk(core_clk),
    .chip_sel_n(chip_sel_n),
    .out_en_n(out_en_n),
    .write_n(write_n),
    .reset_n(reset_n),
    .width_sel(width_sel),
    .word_address_bus(word_address_bus),
    .data_out(data_out),
    .data_oe_n(data_oe_n),
    .data_in(data_in),
    .operation_done_n(operation_done_n)
  );
  always #20 core_clk = ~core_clk;
  task automatic finish_test;
    if (errors == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [15:0] exp_rd(input logic [1:0] m, input logic wm, input logic [17:0] a,
    input logic lsb);
    logic [15:0] w;
    w = m == 2'h0 ? a[15:0] ^ 16'hA5C3 : m == 2'h1 ? 16'h005A : 16'h004C;
    exp_rd = wm ? w : {8'h00, lsb ? w[15:8] : w[7:0]};
  endfunction
  task automatic req(input logic [1:0] op, input logic wm, input logic [17:0] a, input logic lsb,
    input logic [15:0] wd, input logic [15:0] exp);
    int n = 0;
    while (req_ready !== 1'b1 && n < 100) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if (n >= 100)
      errors++;
    {req_op, req_word_mode, req_addr, req_byte_lsb, req_wdata} = {op, wm, a, lsb, wd};
    req_valid = 1'b1;
    @(posedge core_clk);
    #1;
    req_valid = 1'b0;
    n = 0;
    while (op == OP_READ && rsp_valid !== 1'b1 && n < 20) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if (n >= 20)
      errors++;
    if (op == OP_READ)
      check(rsp_rdata, exp);
  endtask
  initial begin
    #200000;
    errors++;
    finish_test;
  end
  initial begin
    logic [17:0] a;
    logic wm, lsb;
    void'($urandom(32'hD3AB22EF));
    repeat (10) @(posedge core_clk);
    #1;
    rst = 1'b0;
    for (int i = 0; i < 24; i++) begin
      a = i == 0 ? 18'h00000 : i == 1 ? 18'h3FFFF : 18'($urandom);
      wm = 1'($urandom);
      lsb = 1'($urandom);
      req(OP_READ, wm, a, lsb, 16'h0000, exp_rd(2'h0, wm, a, lsb));
    end
    for (int i = 0; i < 2; i++) begin
      a = 18'($urandom);
      req(OP_WRITE, i[0], 18'h00555, 1'b0, 16'h0090, 16'h0000);
      req(OP_READ, i[0], a, 1'b0, 16'h0000, exp_rd(2'h1, i[0], a, 1'b0));
      req(OP_WRITE, i[0], 18'h00555, 1'b0, 16'h00F0, 16'h0000);
      req(OP_READ, i[0], a, 1'b1, 16'h0000, exp_rd(2'h0, i[0], a, 1'b1));
    end
    req(OP_WRITE, 1'b1, 18'h2A000, 1'b0, 16'h12A0, 16'h0000);
    req(OP_READ, 1'b1, a, 1'b0, 16'h0000, 16'h004C);
    check({15'h0000, busy}, 16'h0001);
    repeat (20) @(posedge core_clk);
    #1;
    check({15'h0000, busy}, 16'h0000);
    req(OP_WRITE, 1'b0, 18'h00555, 1'b0, 16'h0090, 16'h0000);
    req(OP_RESET, 1'b1, 18'h00000, 1'b0, 16'h0000, 16'h0000);
    req(2'h3, 1'b1, 18'h00000, 1'b0, 16'h0000, 16'h0000);
    req(OP_READ, 1'b1, a, 1'b0, 16'h0000, exp_rd(2'h0, 1'b1, a, 1'b0));
    finish_test;
  end
endmodule
